// ### cpu_flags_and_stack_pointer.sv
// condition flag register and stack pointer of the 8-bit core
// Contract
// - half carry at bit 4 sets on carry from ALU bit 3 into 4 on add
// - half carry changes on add and add-with-carry; other alu ops leave it unchanged
// - negative flag at bit 2 copies result bit 7
// - zero flag at bit 1 is one when result equals zero
// - carry flag at bit 0 shows overflow or borrow of last arithmetic
// - carry forced by set/clear carry; updated by bit test, shift, rotate
// - priority bits 5,3: 10 level0, 01 level1, 00 level2, 11 disable
// - interrupt entry loads priority bits from the vector's priority value
// - priority bits writable by enable, disable, return, halt, wait, push/pop
// - stack pointer is 16 bits, next free location, resets to 01ff
// - push writes then decrements; pop increments then reads
// - upper stack pointer byte held constant; only low byte changes
// - reset or stack reinit instruction sets low byte to all ones
// - low pointer byte readable and writable by load instruction
// - pointer wraps silently past either stack limit
// - interrupt frame writes program counter low first, then lower addresses
// - call uses two stack bytes, interrupt entry uses five
// - interrupt frame holds program counter, X, accumulator, condition flags
// - Y index register is never saved or restored by interrupts
`timescale 1ns/1ps
module cpu_flags_and_stack_pointer
  import cpu_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // alu result for flag update
  input wire cpu_flags_pkg::alu_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  input wire logic alu_carry,
  input wire logic shift_carry,
  // software writes of flags and priority
  input wire logic flags_wr,
  input wire logic [7:0] flags_wdata,
  input wire logic prio_wr,
  input wire logic [1:0] prio_wdata,
  // single push / pop and pointer control
  input wire logic push_req,
  input wire logic [7:0] push_data,
  input wire logic pop_req,
  input wire logic stack_reinit_instr,
  input wire logic load_instr,
  input wire logic [7:0] load_data,
  // frames
  input wire logic frame_start,
  input wire cpu_flags_pkg::frame_t frame_kind,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] index_x,
  input wire logic [7:0] accum,
  input wire logic [1:0] irq_priority_regs,
  // memory port
  input wire logic [7:0] mem_rdata,
  output logic mem_we,
  output logic mem_re,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  // state out
  output logic [7:0] condition_flags,
  output logic [15:0] stack_pointer,
  output logic [7:0] pop_data,
  output logic pop_valid,
  output logic frame_busy,
  output logic frame_done,
  output logic [15:0] restored_pc,
  output logic [7:0] restored_x,
  output logic [7:0] restored_a
);
  import cpu_flags_pkg::*;

  // =========================================================
  // flag update
  // =========================================================
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [4:0] low_nibble_sum;
  logic half_carry;
  logic is_add;
  logic is_data_op;
  logic carry_src_arith;
  logic carry_src_shift;

  assign low_nibble_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}
                          + {4'h0, (alu_op == OP_ADC) & flags_r[CF_CARRY_BIT]};
  assign half_carry = low_nibble_sum[4];
  assign is_add = (alu_op == OP_ADD) || (alu_op == OP_ADC);
  assign is_data_op = is_add || (alu_op == OP_SUB) || (alu_op == OP_LOGIC)
                      || (alu_op == OP_SHIFT);
  assign carry_src_arith = is_add || (alu_op == OP_SUB);
  assign carry_src_shift = (alu_op == OP_SHIFT) || (alu_op == OP_BTJ);

  // stack sequencer signals needed by flag logic
  stk_state_t state_r;
  stk_state_t state_nxt;
  frame_t kind_r;
  logic irq_entry_done;
  logic return_from_irq_instr_flags_load;

  always_comb
  begin
    flags_nxt = flags_r;
    if (flags_wr)
    begin
      flags_nxt = flags_wdata;
    end
    if (is_add)
    begin
      flags_nxt[CF_HALF_BIT] = half_carry;
    end
    if (is_data_op)
    begin
      flags_nxt[CF_NEG_BIT] = alu_result[7];
      flags_nxt[CF_ZERO_BIT] = (alu_result == 8'h00);
    end
    if (carry_src_arith)
    begin
      flags_nxt[CF_CARRY_BIT] = alu_carry;
    end
    else if (carry_src_shift)
    begin
      flags_nxt[CF_CARRY_BIT] = shift_carry;
    end
    else if (alu_op == OP_SET_CARRY)
    begin
      flags_nxt[CF_CARRY_BIT] = 1'b1;
    end
    else if (alu_op == OP_CLEAR_CARRY)
    begin
      flags_nxt[CF_CARRY_BIT] = 1'b0;
    end
    if (prio_wr)
    begin
      flags_nxt[CF_PRIO_HIGH_BIT] = prio_wdata[1];
      flags_nxt[CF_PRIO_LOW_BIT] = prio_wdata[0];
    end
    if (return_from_irq_instr_flags_load)
    begin
      flags_nxt = mem_rdata;
    end
    if (irq_entry_done)
    begin
      flags_nxt[CF_PRIO_HIGH_BIT] = irq_priority_regs[1];
      flags_nxt[CF_PRIO_LOW_BIT] = irq_priority_regs[0];
    end
    flags_nxt = flags_nxt | CF_FIXED_ONES;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      flags_r <= CF_RESET;
    else
      flags_r <= flags_nxt;
  end

  assign condition_flags = flags_r;

  // =========================================================
  // stack pointer
  // =========================================================
  logic [7:0] sp_low_r;
  logic [7:0] sp_low_nxt;
  logic [2:0] step_r;
  logic [2:0] step_nxt;
  logic [2:0] frame_len;
  logic frame_push;
  logic seq_active;
  logic seq_push;
  logic seq_pop;
  logic single_push;
  logic single_pop;

  // wraps naturally in eight bits, no overflow flag by design
  function automatic logic [7:0] sp_step(input logic [7:0] v, input logic down);
    sp_step = down ? v - 8'h01 : v + 8'h01;
  endfunction : sp_step

  assign frame_push = (kind_r == FR_CALL) || (kind_r == FR_IRQ);
  assign frame_len = ((kind_r == FR_IRQ) || (kind_r == FR_RETURN_FROM_IRQ_INSTR))
                     ? 3'(IRQ_FRAME_BYTES) : 3'(CALL_FRAME_BYTES);
  assign seq_active = (state_r != ST_IDLE) && (state_r != ST_DONE);
  assign seq_push = seq_active && frame_push;
  assign seq_pop = seq_active && !frame_push;
  // singles only while idle; reinit and load drop them, push beats pop
  assign single_push = push_req && (state_r == ST_IDLE) && !stack_reinit_instr && !load_instr;
  assign single_pop = pop_req && !push_req && (state_r == ST_IDLE) && !stack_reinit_instr
                      && !load_instr;
  assign irq_entry_done = seq_push && (kind_r == FR_IRQ) && (step_r == frame_len - 3'h1);
  // return pops flags first, then a, x, pch, pcl
  assign return_from_irq_instr_flags_load = seq_pop && (kind_r == FR_RETURN_FROM_IRQ_INSTR) && (step_r == 3'h0);

  always_comb
  begin
    sp_low_nxt = sp_low_r;
    if (stack_reinit_instr)
      sp_low_nxt = SP_LOW_RESET;
    else if (load_instr)
      sp_low_nxt = load_data;
    else if (seq_push || single_push)
      sp_low_nxt = sp_step(sp_low_r, 1'b1);
    else if (seq_pop || single_pop)
      sp_low_nxt = sp_step(sp_low_r, 1'b0);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sp_low_r <= SP_LOW_RESET;
    else
      sp_low_r <= sp_low_nxt;
  end

  assign stack_pointer = {SP_HIGH_BYTE, sp_low_r};

  // =========================================================
  // frame sequencer
  // =========================================================
  logic [7:0] frame_byte;
  logic [15:0] pc_hold_r;
  logic [7:0] x_hold_r;
  logic [7:0] a_hold_r;
  logic [7:0] cf_hold_r;

  // index 0 is pcl: written first at the current pointer
  always_comb
  begin
    case (step_r)
      3'h0: frame_byte = pc_hold_r[7:0];
      3'h1: frame_byte = pc_hold_r[15:8];
      3'h2: frame_byte = x_hold_r;
      3'h3: frame_byte = a_hold_r;
      3'h4: frame_byte = cf_hold_r;
      default: frame_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    step_nxt = step_r;
    case (state_r)
      ST_IDLE:
      begin
        step_nxt = 3'h0;
        if (frame_start)
          state_nxt = ST_B1;
      end
      ST_B1, ST_B2, ST_B3, ST_B4:
      begin
        step_nxt = step_r + 3'h1;
        if (step_r == frame_len - 3'h1)
          state_nxt = ST_DONE;
        else if (state_r == ST_B1)
          state_nxt = ST_B2;
        else if (state_r == ST_B2)
          state_nxt = ST_B3;
        else
          state_nxt = ST_B4;
      end
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      step_r <= 3'h0;
      kind_r <= FR_CALL;
      pc_hold_r <= 16'h0000;
      x_hold_r <= 8'h00;
      a_hold_r <= 8'h00;
      cf_hold_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      if (state_r == ST_IDLE && frame_start)
      begin
        // y index is deliberately not captured
        kind_r <= frame_kind;
        pc_hold_r <= program_counter;
        x_hold_r <= index_x;
        a_hold_r <= accum;
        cf_hold_r <= flags_r;
      end
    end
  end

  // =========================================================
  // memory port and pop capture
  // =========================================================
  logic pop_now;
  logic [2:0] pop_idx;
  logic [15:0] rpc_r;
  logic [7:0] rx_r;
  logic [7:0] ra_r;
  logic [7:0] pop_data_r;
  logic pop_valid_r;

  assign pop_now = seq_pop || single_pop;
  // pops read the byte above the pointer, after the increment
  assign mem_addr = pop_now ? {SP_HIGH_BYTE, sp_step(sp_low_r, 1'b0)}
                            : stack_pointer;
  assign mem_we = seq_push || single_push;
  assign mem_re = pop_now;
  assign mem_wdata = seq_push ? frame_byte : push_data;
  // reversed order: flags, a, x, pch, pcl for return; pch, pcl for ret
  assign pop_idx = frame_len - 3'h1 - step_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rpc_r <= 16'h0000;
      rx_r <= 8'h00;
      ra_r <= 8'h00;
      pop_data_r <= 8'h00;
      pop_valid_r <= 1'b0;
    end
    else
    begin
      pop_valid_r <= single_pop;
      if (single_pop)
        pop_data_r <= mem_rdata;
      if (seq_pop)
      begin
        case (pop_idx)
          3'h0: rpc_r[7:0] <= mem_rdata;
          3'h1: rpc_r[15:8] <= mem_rdata;
          3'h2: rx_r <= mem_rdata;
          3'h3: ra_r <= mem_rdata;
          default: rx_r <= rx_r;
        endcase
      end
    end
  end

  assign pop_data = pop_data_r;
  assign pop_valid = pop_valid_r;
  assign frame_busy = (state_r != ST_IDLE);
  assign frame_done = (state_r == ST_DONE);
  assign restored_pc = rpc_r;
  assign restored_x = rx_r;
  assign restored_a = ra_r;

endmodule : cpu_flags_and_stack_pointer

// ### cpu_flags_pkg.sv
// package: constants for the condition flags and stack pointer block
package cpu_flags_pkg;

  // condition_flags bit positions
  localparam int CF_CARRY_BIT = 0;
  localparam int CF_ZERO_BIT = 1;
  localparam int CF_NEG_BIT = 2;
  localparam int CF_PRIO_LOW_BIT = 3;
  localparam int CF_HALF_BIT = 4;
  localparam int CF_PRIO_HIGH_BIT = 5;

  // unused top bits read as one, priority resets to level 3
  localparam logic [7:0] CF_RESET = 8'he8;
  localparam logic [7:0] CF_FIXED_ONES = 8'hc0;

  // stack geometry
  localparam logic [7:0] SP_HIGH_BYTE = 8'h01;
  localparam logic [7:0] SP_LOW_RESET = 8'hff;
  localparam logic [15:0] SP_RESET = 16'h01ff;

  // two-bit priority codes {high, low}
  localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
  localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
  localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
  localparam logic [1:0] PRIO_LEVEL3 = 2'h3;

  // stack frame sizes
  localparam int CALL_FRAME_BYTES = 2;
  localparam int IRQ_FRAME_BYTES = 5;

  // flag-update operation classes
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_ADC = 4'h2,
    OP_SUB = 4'h3,
    OP_LOGIC = 4'h4,
    OP_SHIFT = 4'h5,
    OP_BTJ = 4'h6,
    OP_SET_CARRY = 4'h7,
    OP_CLEAR_CARRY = 4'h8
  } alu_op_t;

  // stack sequencer states, gray along the frame path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_B1 = 3'h1,
    ST_B2 = 3'h3,
    ST_B3 = 3'h2,
    ST_B4 = 3'h6,
    ST_DONE = 3'h7
  } stk_state_t;

  // frame kinds
  typedef enum logic [1:0] {
    FR_CALL = 2'h0,
    FR_RET = 2'h1,
    FR_IRQ = 2'h2,
    FR_RETURN_FROM_IRQ_INSTR = 2'h3
  } frame_t;

endpackage : cpu_flags_pkg

// ### flags_sp_assertions.sv
// concurrent checks on the flags and stack pointer block
`timescale 1ns/1ps
module flags_sp_assertions
  import cpu_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire cpu_flags_pkg::alu_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  input wire logic flags_wr,
  input wire logic [7:0] flags_wdata,
  input wire logic prio_wr,
  input wire logic [1:0] prio_wdata,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic stack_reinit_instr,
  input wire logic load_instr,
  input wire logic frame_start,
  input wire cpu_flags_pkg::frame_t frame_kind,
  input wire logic [15:0] program_counter,
  input wire logic [1:0] irq_priority_regs,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] condition_flags,
  input wire logic [15:0] stack_pointer,
  input wire logic pop_valid,
  input wire logic frame_busy,
  input wire logic frame_done
);
  // ========
  // helpers
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // a running or starting frame owns pointer and flags
  wire idle = !frame_busy && !frame_start;
  wire sp_ok = idle && !stack_reinit_instr && !load_instr;
  wire set_c = alu_op == OP_SET_CARRY;
  wire [1:0] prio = {condition_flags[5], condition_flags[3]};
  wire [4:0] half = alu_a[3:0] + alu_b[3:0] + (alu_op == OP_ADC && condition_flags[0]);
  sequence irq_start;
    !frame_busy && frame_start && frame_kind == FR_IRQ;
  endsequence
  sequence irq_rest;
    mem_we [*4] ##1 frame_done;
  endsequence
  // ========
  // checks
  chk_sp_high_fixed:
  assert property (stack_pointer[15:8] == SP_HIGH_BYTE) else $error("sp high byte moved");
  chk_push_order:
  assert property (sp_ok && push_req |-> mem_we && mem_addr == stack_pointer
    ##1 stack_pointer[7:0] == $past(stack_pointer[7:0]) - 8'h01) else $error("push order");
  chk_pop_order:
  assert property (sp_ok && pop_req && !push_req |-> mem_re
    && mem_addr == {SP_HIGH_BYTE, stack_pointer[7:0] + 8'h01} ##1 pop_valid)
    else $error("pop order");
  chk_sp_reinit:
  assert property (idle && stack_reinit_instr |=> stack_pointer == SP_RESET)
    else $error("sp reinit");
  chk_half_carry:
  assert property (idle && alu_op inside {OP_ADD, OP_ADC} |=> condition_flags[4] == $past(half[4]))
    else $error("half carry");
  chk_neg_zero:
  assert property (idle && alu_op inside {OP_ADD, OP_SUB, OP_LOGIC} |=>
    condition_flags[2:1] == {$past(alu_result[7]), $past(alu_result) == 8'h00})
    else $error("neg or zero flag");
  chk_carry_force:
  assert property (idle && alu_op inside {OP_SET_CARRY, OP_CLEAR_CARRY} |=>
    condition_flags[0] == $past(set_c)) else $error("carry force");
  chk_flags_write:
  assert property (idle && flags_wr && !prio_wr && alu_op == OP_NONE |=>
    condition_flags == ($past(flags_wdata) | CF_FIXED_ONES)) else $error("flags write");
  chk_prio_write:
  assert property (idle && prio_wr |=> prio == $past(prio_wdata)) else $error("priority write");
  chk_irq_push:
  assert property (irq_start |=> mem_we && mem_wdata == $past(program_counter[7:0])
    && mem_addr == $past(stack_pointer) ##1 irq_rest) else $error("interrupt frame");
  chk_irq_entry:
  assert property (irq_start ##6 frame_done |->
    stack_pointer[7:0] == $past(stack_pointer[7:0], 6) - 8'h05
    && prio == $past(irq_priority_regs))
    else $error("interrupt entry");
endmodule : flags_sp_assertions

bind cpu_flags_and_stack_pointer flags_sp_assertions chk_i (.clk, .rst, .alu_op, .alu_a, .alu_b,
  .alu_result, .flags_wr, .flags_wdata, .prio_wr, .prio_wdata, .push_req, .pop_req,
  .stack_reinit_instr, .load_instr,
  .frame_start, .frame_kind, .program_counter, .irq_priority_regs, .mem_we, .mem_re, .mem_addr,
  .mem_wdata, .condition_flags, .stack_pointer, .pop_valid, .frame_busy, .frame_done);

// ### tb.sv
// testbench for the flags and stack pointer block
`timescale 1ns/1ps
module tb;
  import cpu_flags_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  alu_op_t alu_op = OP_NONE;
  frame_t frame_kind = FR_CALL;
  logic alu_carry = 1'b0, shift_carry = 1'b0, flags_wr = 1'b0, prio_wr = 1'b0;
  logic push_req = 1'b0, pop_req = 1'b0, stack_reinit_instr = 1'b0;
  logic load_instr = 1'b0, frame_start = 1'b0;
  logic [1:0] prio_wdata = 2'h0, irq_priority_regs = 2'h1;
  logic [7:0] alu_a = 8'h00, alu_b = 8'h00, alu_result = 8'h00, flags_wdata = 8'h00;
  logic [7:0] push_data = 8'h00, load_data = 8'h00, index_x = 8'h00, accum = 8'h00;
  logic [15:0] program_counter = 16'h0000;
  logic [7:0] mem_rdata, mem_wdata, condition_flags, pop_data, restored_x, restored_a, exp_f;
  logic [15:0] mem_addr, stack_pointer, restored_pc;
  logic mem_we, mem_re, pop_valid, frame_busy, frame_done;
  logic [7:0] mem [256];
  logic [39:0] saved;
  logic [31:0] seed_r = 32'h000155b9;
  int bad_count = 0;
  int checks_done = 0;

  cpu_flags_and_stack_pointer DUT (.clk, .rst, .alu_op, .alu_a, .alu_b, .alu_result, .alu_carry,
    .shift_carry, .flags_wr, .flags_wdata, .prio_wr, .prio_wdata, .push_req, .push_data,
    .pop_req, .stack_reinit_instr, .load_instr, .load_data, .frame_start, .frame_kind,
    .program_counter, .index_x, .accum, .irq_priority_regs, .mem_rdata, .mem_we, .mem_re,
    .mem_addr, .mem_wdata, .condition_flags, .stack_pointer, .pop_data, .pop_valid,
    .frame_busy, .frame_done, .restored_pc, .restored_x, .restored_a);

  // ========
  // clock and stack memory
  always #20 clk = ~clk;
  assign mem_rdata = mem[mem_addr[7:0]];
  always @(posedge clk)
    if (mem_we === 1'b1)
      mem[mem_addr[7:0]] <= mem_wdata;

  // ========
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [7:0] flags_ref(input alu_op_t op, input logic [8:0] s,
      input logic h, input logic sc, input logic [7:0] f);
    if (op inside {OP_ADD, OP_ADC})
      f[4] = h;
    if (op inside {OP_ADD, OP_ADC, OP_SUB, OP_LOGIC, OP_SHIFT})
      f[2:1] = {s[7], s[7:0] == 8'h00};
    if (op inside {OP_ADD, OP_ADC, OP_SUB})
      f[0] = s[8];
    if (op inside {OP_SHIFT, OP_BTJ})
      f[0] = sc;
    if (op inside {OP_SET_CARRY, OP_CLEAR_CARRY})
      f[0] = op == OP_SET_CARRY;
    return f;
  endfunction : flags_ref

  task automatic check(input string n, input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic alu_step(input alu_op_t op);
    logic [8:0] s;
    logic [4:0] h;
    logic ci;
    seed_r = lfsr_next(seed_r);
    ci = (op == OP_ADC) & exp_f[0];
    alu_a = seed_r[7:0];
    // equal operands make zero results show up often
    alu_b = seed_r[17] ? seed_r[7:0] : seed_r[15:8];
    shift_carry = seed_r[16];
    h = alu_a[3:0] + alu_b[3:0] + ci;
    s = alu_a + alu_b + ci;
    if (op == OP_SUB)
      s = {1'b0, alu_a} - {1'b0, alu_b};
    if (op == OP_LOGIC)
      s = {1'b0, alu_a ^ alu_b};
    if (op == OP_SHIFT)
      s = {shift_carry, alu_a[6:0], 1'b0};
    alu_op = op;
    alu_result = s[7:0];
    alu_carry = s[8];
    exp_f = flags_ref(op, s, h[4], shift_carry, exp_f);
    step;
    check("flags", condition_flags, exp_f);
  endtask : alu_step

  task automatic stack_op(input logic push, input logic [15:0] addr, input logic [15:0] sp);
    step;
    push_req = push;
    pop_req = !push;
    #1 check("mem_addr", mem_addr, addr);
    step;
    push_req = 1'b0;
    pop_req = 1'b0;
    check("sp", stack_pointer, sp);
    check("pop_valid", pop_valid, !push);
    if (!push)
      check("pop_data", pop_data, push_data);
  endtask : stack_op

  task automatic run_frame(input frame_t k);
    step;
    frame_kind = k;
    frame_start = 1'b1;
    step;
    frame_start = 1'b0;
    for (int i = 0; i < 8 && frame_done !== 1'b1; i++)
      step;
    check("frame_done", frame_done, 1'b1);
    step;
  endtask : run_frame

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ========
  // sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    exp_f = CF_RESET;
    check("sp", stack_pointer, SP_RESET);
    for (int i = 0; i < 90; i++)
      alu_step(alu_op_t'(i % 9));
    alu_op = OP_NONE;
    prio_wr = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      prio_wdata = 2'(p);
      step;
      check("prio", {condition_flags[5], condition_flags[3]}, prio_wdata);
    end
    prio_wr = 1'b0;
    exp_f = exp_f | 8'h28;
    load_instr = 1'b1;
    step;
    load_instr = 1'b0;
    check("sp", stack_pointer, 16'h0100);
    push_data = seed_r[23:16];
    stack_op(1'b1, 16'h0100, 16'h01ff);
    stack_op(1'b0, 16'h0100, 16'h0100);
    stack_reinit_instr = 1'b1;
    step;
    stack_reinit_instr = 1'b0;
    check("sp", stack_pointer, SP_RESET);
    program_counter = seed_r[15:0];
    index_x = seed_r[23:16];
    accum = seed_r[31:24];
    saved = {program_counter[7:0], program_counter[15:8], index_x, accum, exp_f};
    run_frame(FR_IRQ);
    check("sp", stack_pointer, 16'h01fa);
    check("prio", {condition_flags[5], condition_flags[3]}, 2'h1);
    check("frame", {mem[255], mem[254], mem[253], mem[252], mem[251]}, saved);
    program_counter = ~program_counter;
    run_frame(FR_RETURN_FROM_IRQ_INSTR);
    check("restored", {restored_pc, restored_x, restored_a}, {~program_counter, saved[23:8]});
    check("flags", condition_flags, exp_f);
    run_frame(FR_CALL);
    check("sp", stack_pointer, 16'h01fd);
    run_frame(FR_RET);
    check("ret_pc", restored_pc, program_counter);
    check("sp", stack_pointer, SP_RESET);
    seed_r = lfsr_next(seed_r);
    flags_wdata = seed_r[7:0];
    flags_wr = 1'b1;
    step;
    flags_wr = 1'b0;
    check("flags", condition_flags, seed_r[7:0] | CF_FIXED_ONES);
    complete_run;
  end

  initial
  begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule : tb
